// File: ciq_common_status.sv
// Purpose: interrupt request latching, masking, clearing and diagnostic status reads
// Assumes: host strobes and sync pins are asynchronous, framer events are on clock
// Notes: host strobes are resampled, so each strobe must last at least three clock cycles
`timescale 1ns/1ps
module ciq_common_status #(
    parameter int NUM_CH = ciq_pkg::NCH
)(
    input  wire logic                clock,
    input  wire logic                arst_n,
    input  wire logic                mpu_cs_n,
    input  wire logic                mpu_rd_n,
    input  wire logic                mpu_wr_n,
    input  wire logic [7:0]          mpu_addr,
    input  wire logic [7:0]          mpu_wdata,
    output logic [7:0]               mpu_rdata,
    output logic                     mpu_rdata_oe,
    input  wire ciq_pkg::ciq_events_t events,
    input  wire ciq_pkg::ciq_cfg_t   cfg,
    input  wire logic [15:0]         nco_residual_phase,
    input  wire logic signed [15:0]  pll_phase_raw,
    input  wire logic                pcm_tx_clock,
    input  wire logic                tx_multiframe_sync,
    input  wire logic                rx_multiframe_sync,
    input  wire logic                hdsl_multiframe_sync,
    output logic                     irq_out_n
);
    import ciq_pkg::*;

    // the register layout has room for exactly three channels
    if (NUM_CH != NCH)
    begin : g_ch_check
        $error("channel count fixed by register layout");
    end

    // two-stage resync of every host bus and sync pin; stage one is read only by stage two
    localparam int PW = 3 + 8 + 8 + 4;
    logic [PW-1:0] pin_s1_r;
    logic [PW-1:0] pin_s2_r;
    logic [PW-1:0] pin_raw;
    assign pin_raw = {mpu_cs_n, mpu_rd_n, mpu_wr_n, mpu_addr, mpu_wdata,
                      pcm_tx_clock, tx_multiframe_sync, rx_multiframe_sync, hdsl_multiframe_sync};

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_s1_r <= {3'h7, 8'h00, 8'h00, 4'h0};
            pin_s2_r <= {3'h7, 8'h00, 8'h00, 4'h0};
        end
        else
        begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
        end
    end

    logic       cs_n_s;
    logic       rd_n_s;
    logic       wr_n_s;
    logic [7:0] addr_s;
    logic [7:0] wdata_s;
    logic [3:0] sync_s;
    assign {cs_n_s, rd_n_s, wr_n_s, addr_s, wdata_s, sync_s} = pin_s2_r;

    // edge history of resynced levels
    logic       rd_act_d_r;
    logic       wr_act_d_r;
    logic [3:0] sync_d_r;
    logic       rd_act;
    logic       wr_act;
    logic       rd_start;
    logic       wr_end;
    logic [3:0] sync_rise;
    assign rd_act    = !cs_n_s && !rd_n_s;
    assign wr_act    = !cs_n_s && !wr_n_s;
    assign rd_start  = rd_act && !rd_act_d_r;
    // write taken at strobe end so the data lines have settled
    assign wr_end    = wr_act_d_r && !wr_act;
    assign sync_rise = sync_s & ~sync_d_r;

    logic [7:0] wr_addr_r;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_act_d_r <= 1'b0;
            wr_act_d_r <= 1'b0;
            sync_d_r   <= 4'h0;
            wr_addr_r  <= 8'h00;
        end
        else
        begin
            rd_act_d_r <= rd_act;
            wr_act_d_r <= wr_act;
            sync_d_r   <= sync_s;
            if (wr_act)
                wr_addr_r <= addr_s;
        end
    end

    logic [7:0] wr_data_r;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            wr_data_r <= 8'h00;
        else if (wr_act)
            wr_data_r <= wdata_s;
    end

    logic wr_mask;
    logic wr_clear;
    assign wr_mask  = wr_end && (wr_addr_r == ADDR_IRQ_MASK);
    assign wr_clear = wr_end && (wr_addr_r == ADDR_IRQ_CLEAR);

    // write echo and mask
    logic [7:0] wr_echo_r;
    logic [7:0] irq_mask_r;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            wr_echo_r <= 8'h00;
        else if (wr_end)
            wr_echo_r <= wr_data_r; // RQ14
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            irq_mask_r <= RST_MASK;
        else if (wr_mask)
            irq_mask_r <= wr_data_r; // RQ21
    end

    // phase error saturation and limit detection
    logic [7:0] phs_sat;
    logic       phs_at_limit;
    always_comb
    begin
        if (pll_phase_raw > $signed({8'h00, PHS_MAX}))
            phs_sat = PHS_MAX; // RQ11
        else if (pll_phase_raw < $signed({8'hff, PHS_MIN}))
            phs_sat = PHS_MIN; // RQ11
        else
            phs_sat = pll_phase_raw[7:0];
        phs_at_limit = (phs_sat == PHS_MAX) || (phs_sat == PHS_MIN); // RQ20
    end

    // error source levels
    logic [NCH-1:0] tx_src;
    logic [NCH-1:0] rx_src;
    logic           pll_src;
    logic [NCH-1:0] tx_src_en;
    logic [NCH-1:0] rx_src_en;
    logic           pll_src_en;
    logic           rx_persist;
    assign tx_src     = events.tx_err_event;
    assign rx_src     = events.rx_err_event | events.framer_unlocked;
    assign pll_src    = phs_at_limit;
    assign tx_src_en  = tx_src & cfg.tx_fault_enable; // RQ17
    assign rx_src_en  = rx_src & cfg.rx_fault_enable; // RQ17
    assign pll_src_en = pll_src & cfg.pll_fault_enable; // RQ17
    assign rx_persist = |(events.framer_unlocked & cfg.rx_fault_enable);

    logic tx_err_lvl;
    logic rx_err_lvl;
    logic tx_err_d_r;
    logic rx_err_d_r;
    assign tx_err_lvl = |tx_src_en; // RQ8
    assign rx_err_lvl = (|rx_src_en) || pll_src_en; // RQ9

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_err_d_r <= 1'b0;
            rx_err_d_r <= 1'b0;
        end
        else
        begin
            tx_err_d_r <= tx_err_lvl;
            rx_err_d_r <= rx_err_lvl;
        end
    end

    // one error event per rising edge, so a lingering or stacked error asks once; frame starts pass through as levels
    logic [7:0] irq_event;
    always_comb
    begin
        irq_event                    = 8'h00;
        irq_event[BIT_RX_ERR]        = rx_err_lvl && !rx_err_d_r; // RQ5
        irq_event[BIT_TX_ERR]        = tx_err_lvl && !tx_err_d_r; // RQ5
        irq_event[BIT_RX_FRM +: NCH] = events.rx_frame_start; // RQ7 RQ22
        irq_event[BIT_TX_FRM +: NCH] = events.tx_frame_start; // RQ6 RQ22
    end

    logic [7:0] persist_hold;
    assign persist_hold = {rx_persist, 7'h00};

    // request flags and pending interrupts
    logic [7:0] irq_flags_r;
    logic [7:0] irq_pend_r;
    logic [7:0] clr_bits;
    assign clr_bits = wr_clear ? ~wr_data_r : 8'h00; // RQ3

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            irq_flags_r <= 8'h00;
        else
            irq_flags_r <= irq_event | (irq_flags_r & ~(clr_bits & ~persist_hold)); // RQ1 RQ3 RQ4
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            irq_pend_r <= 8'h00;
        else
            irq_pend_r <= irq_event | (irq_pend_r & ~clr_bits); // RQ1 RQ4
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            irq_out_n <= 1'b1;
        else
            irq_out_n <= !(|(irq_pend_r & ~irq_mask_r)); // RQ2 RQ24
    end

    // error source flags, read clears, a new event in the read cycle survives
    logic [7:0] err_src_r;
    logic [7:0] err_set;
    logic       rd_err;
    // fault bits latch whatever the enables say; enables only gate the summary requests
    always_comb
    begin
        err_set                    = 8'h00;
        err_set[BIT_PLL_FLT]       = pll_src; // RQ20
        err_set[BIT_RX_FLT +: NCH] = rx_src; // RQ19
        err_set[BIT_TX_FLT +: NCH] = tx_src; // RQ18 RQ23
    end
    assign rd_err  = rd_start && (addr_s == ADDR_ERR_SRC);

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            err_src_r <= 8'h00;
        else if (rd_err)
            err_src_r <= err_set; // RQ15
        else
            err_src_r <= err_src_r | err_set; // RQ16
    end

    // master channel frame snapshots of pll state
    logic        master_rx_frame;
    logic [15:0] resid_r;
    logic [7:0]  pll_phase_error_r;
    assign master_rx_frame = events.rx_frame_start[cfg.master_channel];

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            resid_r   <= 16'h0000;
            pll_phase_error_r <= 8'h00;
        end
        else if (master_rx_frame)
        begin
            resid_r   <= nco_residual_phase; // RQ10
            pll_phase_error_r <= phs_sat; // RQ11
        end
    end

    // multiframe phase counter, pcm clock is sampled so it must run well below clock/4
    logic           pcm_tx_clock_rise;
    logic           start_rise;
    logic           stop_rise;
    logic           mf_run_r;
    logic           mf_seen_r;
    logic [PHW-1:0] mf_cnt_r;
    logic [PHW-1:0] mf_phase_r;
    assign pcm_tx_clock_rise  = sync_rise[3];
    assign start_rise = cfg.phase_source_select ? sync_rise[1] : sync_rise[2];
    assign stop_rise  = sync_rise[0];

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mf_run_r  <= 1'b0;
            mf_seen_r <= 1'b0;
            mf_cnt_r  <= '0;
        end
        else if (start_rise)
        begin
            mf_run_r  <= 1'b1; // RQ12
            mf_seen_r <= 1'b0;
            mf_cnt_r  <= '0;
        end
        else if (stop_rise)
            mf_run_r <= 1'b0;
        // the first pcm clock edge only opens the first cycle, so one cycle reads as zero
        else if (mf_run_r && pcm_tx_clock_rise && !mf_seen_r)
            mf_seen_r <= 1'b1; // RQ12
        else if (mf_run_r && pcm_tx_clock_rise && mf_cnt_r != MFPH_MAX)
            mf_cnt_r <= mf_cnt_r + 13'h0001; // RQ12 RQ13
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            mf_phase_r <= '0;
        else if (stop_rise && mf_run_r)
            mf_phase_r <= mf_cnt_r; // RQ12
    end

    // read mux, data driven from a flop while the read strobe is active
    logic [7:0] rd_mux;
    always_comb
    begin
        unique case (addr_s)
            ADDR_IRQ_FLAGS: rd_mux = irq_flags_r; // RQ22
            ADDR_RESID_HI:  rd_mux = resid_r[15:8]; // RQ10
            ADDR_RESID_LO:  rd_mux = resid_r[7:0]; // RQ10
            ADDR_MASK_RB:   rd_mux = irq_mask_r; // RQ21
            ADDR_PLL_PHASE_ERROR:   rd_mux = pll_phase_error_r; // RQ11
            ADDR_MFPH_LO:   rd_mux = mf_phase_r[7:0]; // RQ13
            ADDR_MFPH_HI:   rd_mux = {3'h0, mf_phase_r[12:8]}; // RQ13
            ADDR_WR_ECHO:   rd_mux = wr_echo_r; // RQ14
            ADDR_ERR_SRC:   rd_mux = err_src_r; // RQ15
            default:        rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mpu_rdata    <= 8'h00;
            mpu_rdata_oe <= 1'b0;
        end
        else
        begin
            if (rd_start)
                mpu_rdata <= rd_mux;
            mpu_rdata_oe <= rd_act;
        end
    end
endmodule // ciq_common_status

// File: ciq_common_status_asserts.sv
// Purpose: port checks on the interrupt output and the host read path
// Assumes: host strobes last at least three cycles
// Notes: the mask is not visible here, so interrupt edges are tied to their causes
`timescale 1ns/1ps
module ciq_status_chk (
    input wire logic                 clock,
    input wire logic                 arst_n,
    input wire logic                 mpu_cs_n,
    input wire logic                 mpu_rd_n,
    input wire logic                 mpu_wr_n,
    input wire logic [7:0]           mpu_rdata,
    input wire logic                 mpu_rdata_oe,
    input wire ciq_pkg::ciq_events_t events,
    input wire logic                 irq_out_n
);
    import ciq_pkg::*;
    logic [3:0] ev_age_r;
    logic [3:0] wr_age_r;
    logic [3:0] rd_age_r;
    logic [3:0] rd_idle_r;
    logic       rd_act;
    assign rd_act = !mpu_cs_n && !mpu_rd_n;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // ages saturate, so a long quiet spell never wraps into a false cause
    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n) ev_age_r <= 4'hf;
        else ev_age_r <= (events != '0) ? 4'h0 : ev_age_r + {3'h0, ev_age_r != 4'hf};
    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n) wr_age_r <= 4'hf;
        else wr_age_r <= (!mpu_cs_n && !mpu_wr_n) ? 4'h0 : wr_age_r + {3'h0, wr_age_r != 4'hf};
    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n) rd_age_r <= 4'h0;
        else rd_age_r <= !rd_act ? 4'h0 : rd_age_r + {3'h0, rd_age_r != 4'hf};
    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n) rd_idle_r <= 4'hf;
        else rd_idle_r <= rd_act ? 4'h0 : rd_idle_r + {3'h0, rd_idle_r != 4'hf};
    property p_ic; $fell(irq_out_n) |-> (ev_age_r < 4'h6) || (wr_age_r < 4'h9); endproperty
    a_ic: assert property (p_ic) else $error("irq fell without an event");
    property p_ir; $rose(irq_out_n) |-> wr_age_r < 4'h9; endproperty
    a_ir: assert property (p_ir) else $error("irq released without a write");
    property p_il; (!irq_out_n && wr_age_r > 4'h8) |=> !irq_out_n; endproperty
    a_il: assert property (p_il) else $error("irq dropped on its own");
    property p_rs; $rose(arst_n) |-> irq_out_n && !mpu_rdata_oe; endproperty
    a_rs: assert property (p_rs) else $error("outputs active after reset");
    property p_or; $rose(mpu_rdata_oe) |-> rd_age_r inside {[4'h2:4'h6]}; endproperty
    a_or: assert property (p_or) else $error("data enable rose off a read");
    property p_od; $rose(mpu_rd_n) |-> ##[1:6] !mpu_rdata_oe; endproperty
    a_od: assert property (p_od) else $error("data enable held too long");
    property p_oi; rd_idle_r > 4'h6 |-> !mpu_rdata_oe; endproperty
    a_oi: assert property (p_oi) else $error("data enable while idle");
    property p_st; mpu_rdata_oe && $past(mpu_rdata_oe) |-> $stable(mpu_rdata); endproperty
    a_st: assert property (p_st) else $error("read data moved during read");
endmodule // ciq_status_chk

// File: ciq_host_model.sv
// Purpose: host processor model for the parallel register bus
// Assumes: strobe held six cycles, then five idle cycles
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module ciq_host_model (
    input  wire logic       clock,
    input  wire logic [7:0] mpu_rdata,
    input  wire logic       mpu_rdata_oe,
    output logic            mpu_cs_n,
    output logic            mpu_rd_n,
    output logic            mpu_wr_n,
    output logic [7:0]      mpu_addr,
    output logic [7:0]      mpu_wdata
);
    initial {mpu_addr, mpu_wdata, mpu_cs_n, mpu_rd_n, mpu_wr_n} = {16'h0, 3'h7};
    // w high selects a write; read data is taken before the strobe lets go
    task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic ok);
        @(posedge clock);
        #1;
        {mpu_addr, mpu_wdata, mpu_cs_n, mpu_rd_n, mpu_wr_n} = {a, d, 1'b0, w, !w};
        repeat (6) @(posedge clock);
        #1;
        q = mpu_rdata;
        ok = mpu_rdata_oe;
        {mpu_addr, mpu_wdata, mpu_cs_n, mpu_rd_n, mpu_wr_n} = {~a, ~d, 3'h7};
        repeat (5) @(posedge clock);
    endtask
endmodule // ciq_host_model

// File: ciq_pkg.sv
// Purpose: shared constants and types for the common interrupt and diagnostic status block
// Assumes: 8-bit parallel host bus, three hdsl channels
// Notes: register offsets are byte addresses on the host bus
// Functional notes
// RQ1: latch request flag, assert interrupt on event
// RQ2: masked sources latch but stay off output
// RQ3: writing 0 to clear bit resets flag
// RQ4: persistent condition keeps flag, output drops; here only an enabled framer_unlocked holds the rx err flag
// RQ5: edge triggered, one request per condition
// RQ6: transmit frame flag per channel at start
// RQ7: receive frame flag per channel at start
// RQ8: transmit error is OR of enabled sources
// RQ9: receive error is OR of enabled sources
// RQ10: residual phase high/low, updated on master frame
// RQ11: phase error saturates 0x80..0x7f, master update
// RQ12: multiframe phase counts tx clocks between syncs
// RQ13: 13-bit phase, low and high bytes
// RQ14: echo register holds last write data
// RQ15: error source read returns then clears
// RQ16: each channel fault latched until read
// RQ17: per-source enable gates error interrupt
// RQ18: per-channel transmit fault with transmit error
// RQ19: per-channel receive fault with receive error
// RQ20: pll fault at phase error limit
// RQ21: mask readback returns last mask write
// RQ22: request bits: rx err, tx err, rx, tx
// RQ23: error bits: pll 6, rx 5:3, tx 2:0
// RQ24: interrupt output active low while pending
package ciq_pkg;
    localparam int          NCH             = 3;
    localparam int          AW              = 8;
    localparam int          DW              = 8;
    localparam int          PHW             = 13;
    localparam logic [7:0]  ADDR_IRQ_FLAGS  = 8'h1f;
    localparam logic [7:0]  ADDR_RESID_HI   = 8'h20;
    localparam logic [7:0]  ADDR_RESID_LO   = 8'h28;
    localparam logic [7:0]  ADDR_MASK_RB    = 8'h30;
    localparam logic [7:0]  ADDR_PLL_PHASE_ERROR    = 8'h38;
    localparam logic [7:0]  ADDR_MFPH_LO    = 8'h39;
    localparam logic [7:0]  ADDR_MFPH_HI    = 8'h3a;
    localparam logic [7:0]  ADDR_WR_ECHO    = 8'h3b;
    localparam logic [7:0]  ADDR_ERR_SRC    = 8'h3c;
    localparam logic [7:0]  ADDR_IRQ_MASK   = 8'heb;
    localparam logic [7:0]  ADDR_IRQ_CLEAR  = 8'hec;
    localparam int          BIT_RX_ERR      = 7;
    localparam int          BIT_TX_ERR      = 6;
    localparam int          BIT_RX_FRM      = 3;
    localparam int          BIT_TX_FRM      = 0;
    localparam int          BIT_PLL_FLT     = 6;
    localparam int          BIT_RX_FLT      = 3;
    localparam int          BIT_TX_FLT      = 0;
    localparam logic [7:0]  RST_MASK        = 8'h00;
    localparam logic [7:0]  PHS_MAX         = 8'h7f;
    localparam logic [7:0]  PHS_MIN         = 8'h80;
    localparam logic [12:0] MFPH_MAX        = 13'h1fff;

    typedef struct packed {
        logic [NCH-1:0] tx_frame_start;
        logic [NCH-1:0] rx_frame_start;
        logic [NCH-1:0] tx_err_event;
        logic [NCH-1:0] rx_err_event;
        logic [NCH-1:0] framer_unlocked;
    } ciq_events_t;

    typedef struct packed {
        logic [NCH-1:0] tx_fault_enable;
        logic [NCH-1:0] rx_fault_enable;
        logic           pll_fault_enable;
        logic [1:0]     master_channel;
        logic           phase_source_select;
    } ciq_cfg_t;
endpackage : ciq_pkg

// File: tb_common_irq_and_diag_status.sv
// Purpose: self-checking bench for the common interrupt and status block
// Assumes: host model paces every register access
// Notes: expected flags and fault bits are kept in plain ints
`timescale 1ns/1ps
module tb_common_irq_and_diag_status;
    import ciq_pkg::*;
    logic clock = 0, arst_n = 0, pcm = 0, tms = 0, rms = 0, hms = 0;
    logic cs_n, rd_n, wr_n, oe, irq_n, ok;
    logic [7:0] addr, wdata, rdata, d;
    logic [15:0] resid = 16'h0;
    logic signed [15:0] praw = 16'sh0;
    ciq_events_t ev = '0, v;
    ciq_cfg_t cfg = '0;
    int num_errors = 0, check_count = 0, ef, ee, k, pl = 0;
    int q[$];
    always #5 clock = ~clock;
    ciq_common_status ciq_common_status_i (.clock(clock), .arst_n(arst_n), .mpu_cs_n(cs_n), .mpu_rd_n(rd_n),
        .mpu_wr_n(wr_n), .mpu_addr(addr), .mpu_wdata(wdata), .mpu_rdata(rdata), .mpu_rdata_oe(oe),
        .events(ev), .cfg(cfg), .nco_residual_phase(resid), .pll_phase_raw(praw), .pcm_tx_clock(pcm),
        .tx_multiframe_sync(tms), .rx_multiframe_sync(rms), .hdsl_multiframe_sync(hms), .irq_out_n(irq_n));
    ciq_host_model ciq_host_model_i (.clock(clock), .mpu_rdata(rdata), .mpu_rdata_oe(oe), .mpu_cs_n(cs_n),
        .mpu_rd_n(rd_n), .mpu_wr_n(wr_n), .mpu_addr(addr), .mpu_wdata(wdata));
    task automatic bad(input string s);
        num_errors++;
        $display("BAD %0t %s", $time, s);
    endtask
    task automatic rd(input logic [7:0] a, input int e);
        ciq_host_model_i.cyc(1'b0, a, 8'h0, d, ok);
        check_count++;
        if (d !== e[7:0] || ok !== 1'b1) bad($sformatf("read %h got %h exp %h", a, d, e[7:0]));
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        ciq_host_model_i.cyc(1'b1, a, x, d, ok);
    endtask
    task automatic irq(input logic e);
        repeat (3) @(posedge clock);
        #1;
        check_count++;
        if (irq_n !== e) bad("irq level");
    endtask
    task automatic pulse(input ciq_events_t p);
        @(posedge clock);
        #1 ev = ev | p;
        @(posedge clock);
        #1 ev = ev & ~p;
    endtask
    task automatic clr(input int b);
        wr(ADDR_IRQ_CLEAR, ~(8'h01 << b));
    endtask
    task automatic print_verdict;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #1000000;
        bad("timeout");
        print_verdict();
    end
    initial
    begin
        void'($urandom(65));
        repeat (3) @(posedge clock);
        #1 arst_n = 1'b1;
        rd(ADDR_IRQ_FLAGS, 0);
        rd(ADDR_MASK_RB, 0);
        rd(8'h55, 0);
        for (int i = 0; i < 6; i++)
        begin
            v = '0;
            if (i < 3) v.tx_frame_start[i] = 1'b1;
            else v.rx_frame_start[i-3] = 1'b1;
            pulse(v);
            irq(1'b0);
            rd(ADDR_IRQ_FLAGS, 1 << i);
            clr(i);
            irq(1'b1);
            rd(ADDR_IRQ_FLAGS, 0);
        end
        repeat (4)
        begin
            k = $urandom_range(255);
            wr(ADDR_IRQ_MASK, k[7:0]);
            rd(ADDR_MASK_RB, k);
            v = '0;
            v.rx_frame_start[2] = 1'b1;
            pulse(v);
            irq(k[5]);
            rd(ADDR_IRQ_FLAGS, 8'h20);
            clr(5);
            rd(ADDR_WR_ECHO, 8'hdf);
        end
        wr(ADDR_IRQ_MASK, 8'h00);
        #1 cfg.tx_fault_enable = 3'h6;
        for (int c = 0; c < 3; c++)
        begin
            v = '0;
            v.tx_err_event[c] = 1'b1;
            pulse(v);
            ee = 1 << c;
            ef = (c == 0) ? 0 : 8'h40;
            irq(c == 0);
            rd(ADDR_IRQ_FLAGS, ef);
            rd(ADDR_ERR_SRC, ee);
            rd(ADDR_ERR_SRC, 0);
            clr(6);
        end
        #1 cfg.rx_fault_enable = 3'h7;
        @(posedge clock);
        #1 ev.framer_unlocked[1] = 1'b1;
        irq(1'b0);
        rd(ADDR_ERR_SRC, 8'h10);
        clr(7);
        irq(1'b1);
        rd(ADDR_IRQ_FLAGS, 8'h80);
        #1 ev.framer_unlocked[2] = 1'b1;
        irq(1'b1);
        #1 ev.framer_unlocked = 3'h0;
        clr(7);
        rd(ADDR_IRQ_FLAGS, 0);
        ciq_host_model_i.cyc(1'b0, ADDR_ERR_SRC, 8'h0, d, ok);
        q = '{300, -300, 37, -128};
        foreach (q[j])
        begin
            k = $urandom_range(2);
            #1 cfg.master_channel = k[1:0];
            cfg.pll_fault_enable = 1'b1;
            resid = 16'($urandom);
            praw = 16'(q[j]);
            v = '0;
            v.rx_frame_start[k] = 1'b1;
            pulse(v);
            rd(ADDR_RESID_HI, resid[15:8]);
            rd(ADDR_RESID_LO, resid[7:0]);
            ee = q[j] > 127 ? 8'h7f : (q[j] < -128 ? 8'h80 : q[j] & 8'hff);
            rd(ADDR_PLL_PHASE_ERROR, ee);
            // a fault level still standing when the last read cleared the bit has set it again
            ef = (ee == 8'h7f || ee == 8'h80) ? 8'h40 : 0;
            rd(ADDR_ERR_SRC, ef | pl);
            pl = ef;
            wr(ADDR_IRQ_CLEAR, 8'h00);
        end
        for (int s = 0; s < 2; s++)
        begin
            #1 cfg.phase_source_select = s[0];
            k = $urandom_range(600, 2);
            {tms, rms} = s ? 2'h1 : 2'h2;
            repeat (k)
            begin
                #40 pcm = 1'b1;
                #40 pcm = 1'b0;
            end
            #20 hms = 1'b1;
            #80 {tms, rms, hms} = 3'h0;
            rd(ADDR_MFPH_LO, (k - 1) & 8'hff);
            rd(ADDR_MFPH_HI, (k - 1) >> 8);
        end
        k = $urandom_range(255);
        wr(8'h77, k[7:0]);
        rd(ADDR_WR_ECHO, k);
        print_verdict();
    end
endmodule // tb_common_irq_and_diag_status
bind ciq_common_status ciq_status_chk ciq_status_chk_i (.clock(clock), .arst_n(arst_n), .mpu_cs_n(mpu_cs_n),
    .mpu_rd_n(mpu_rd_n), .mpu_wr_n(mpu_wr_n), .mpu_rdata(mpu_rdata), .mpu_rdata_oe(mpu_rdata_oe),
    .events(events), .irq_out_n(irq_out_n));
